// >>> logic/pad_pll_control.v
// control, feedback selection, lock and output logic of the pad-sourced synthesizer
`timescale 1ns/1ps
`include "pad_pll_defines.vh"

module pad_pll_control (
  clk,
  rstn,
  loopResetN,
  padClockIn,
  outsideFeedbackInput,
  bypassIn,
  lowPowerIn,
  runtimeDelayBus,
  testSerialIn,
  testSerialOut,
  regAddr,
  regWrData,
  regWr,
  regRd,
  regRdData,
  portAGlobalOut,
  portAFabricOut,
  portBGlobalOut,
  portBFabricOut,
  lockOut
);
  input wire clk;
  input wire rstn;
  input wire loopResetN;
  input wire padClockIn;
  input wire outsideFeedbackInput;
  input wire bypassIn;
  input wire lowPowerIn;
  input wire [7:0] runtimeDelayBus;
  input wire testSerialIn;
  output wire testSerialOut;
  input wire [7:0] regAddr;
  input wire [31:0] regWrData;
  input wire regWr;
  input wire regRd;
  output reg [31:0] regRdData;
  output wire portAGlobalOut;
  output wire portAFabricOut;
  output wire portBGlobalOut;
  output wire portBFabricOut;
  output wire lockOut;

  // ----------------------------------------------------------------
  // pin synchronisers: three flops, change taken when 2nd and 3rd agree
  // ----------------------------------------------------------------
  wire [3:0] pinRaw;
  wire [3:0] pinState;
  genvar i;

  assign pinRaw = {bypassIn, lowPowerIn, outsideFeedbackInput, padClockIn};

  generate
    for (i = 0; i < 4; i = i + 1) begin : gSync
      reg s1Reg;
      reg s2Reg;
      reg s3Reg;
      reg stateReg;
      always @(posedge clk) begin
        if (!rstn) begin
          s1Reg <= 1'b0;
          s2Reg <= 1'b0;
          s3Reg <= 1'b0;
          stateReg <= 1'b0;
        end else begin
          s1Reg <= pinRaw[i];
          s2Reg <= s1Reg;
          s3Reg <= s2Reg;
          if (s2Reg == s3Reg) begin
            stateReg <= s3Reg;
          end
        end
      end
      assign pinState[i] = stateReg;
    end
  endgenerate

  wire padState = pinState[0];
  wire outsideState = pinState[1];
  wire lowPowerState = pinState[2];
  wire bypassState = pinState[3];

  // test pins serve factory test only; output parked low
  assign testSerialOut = 1'b0;

  // ----------------------------------------------------------------
  // loop reset: asserts at once, releases on the clock
  // ----------------------------------------------------------------
  reg loopRstMetaReg;
  reg loopRstNReg;

  always @(posedge clk or negedge loopResetN) begin
    if (!loopResetN) begin
      loopRstMetaReg <= 1'b0;
      loopRstNReg <= 1'b0;
    end else begin
      loopRstMetaReg <= 1'b1;
      loopRstNReg <= loopRstMetaReg;
    end
  end

  wire loopHold = !loopRstNReg || !rstn;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg [9:0] cfgReg;
  reg [7:0] dlyReg;
  reg [15:0] divReg;
  reg rejectReg;

  wire [1:0] fbPath = cfgReg[`CFG_PATH_LSB +: 2];
  wire fbDynamic = cfgReg[`CFG_FBMODE_BIT];
  wire relDynamic = cfgReg[`CFG_RELMODE_BIT];
  wire divMode = cfgReg[`CFG_DIVMODE_BIT];
  wire [1:0] outSel = cfgReg[`CFG_OUTSEL_LSB +: 2];
  wire pdEnable = cfgReg[`CFG_PDEN_BIT];
  wire pdEnableA = cfgReg[`CFG_PDEN_A_BIT];
  wire pdEnableB = cfgReg[`CFG_PDEN_B_BIT];
  wire [2:0] outDiv = divReg[`DIV_OUT_LSB +: 3];

  // reference, feedback dividers and filter take any value their field can hold
  wire [2:0] wrOutDiv = regWrData[`DIV_OUT_LSB +: 3];
  wire divWrOk = (wrOutDiv >= `OUT_DIV_MIN) && (wrOutDiv <= `OUT_DIV_MAX);
  wire divWr = regWr && (regAddr == `DIV_OFFSET);
  wire rejectSet = divWr && !divWrOk;
  wire rejectClr = regWr && (regAddr == `STAT_OFFSET) && regWrData[`STAT_REJECT_BIT];

  always @(posedge clk) begin
    if (!rstn) begin
      cfgReg <= `CFG_RESET;
      dlyReg <= `DLY_RESET;
      divReg <= `DIV_RESET;
      rejectReg <= 1'b0;
    end else begin
      if (regWr && (regAddr == `CFG_OFFSET)) begin
        cfgReg <= regWrData[9:0];
      end
      if (regWr && (regAddr == `DLY_OFFSET)) begin
        dlyReg <= regWrData[7:0];
      end
      // an out-of-range divider write is refused whole
      if (divWr && divWrOk) begin
        divReg <= regWrData[15:0];
      end
      // a refusal in the clearing cycle still sticks
      if (rejectSet) begin
        rejectReg <= 1'b1;
      end else if (rejectClr) begin
        rejectReg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // synthesized clock, half rate and phase shifter
  // ----------------------------------------------------------------
  reg [2:0] halfCntReg;
  reg synthReg;
  reg halfRateReg;
  reg [1:0] johnsonReg;
  reg [2:0] div7Reg;

  wire synthToggle = (halfCntReg >= outDiv - 3'h1);
  wire synthRise = synthToggle && !synthReg;

  always @(posedge clk or negedge loopResetN) begin
    if (!loopResetN) begin
      halfCntReg <= 3'h0;
      synthReg <= 1'b0;
      halfRateReg <= 1'b0;
      johnsonReg <= 2'h0;
      div7Reg <= 3'h0;
    end else if (loopHold) begin
      halfCntReg <= 3'h0;
      synthReg <= 1'b0;
      halfRateReg <= 1'b0;
      johnsonReg <= 2'h0;
      div7Reg <= 3'h0;
    end else begin
      if (synthToggle) begin
        halfCntReg <= 3'h0;
        synthReg <= ~synthReg;
      end else begin
        halfCntReg <= halfCntReg + 3'h1;
      end
      if (synthRise) begin
        halfRateReg <= ~halfRateReg;
        johnsonReg <= {johnsonReg[0], ~johnsonReg[1]};
        div7Reg <= (div7Reg == `SHIFT_DIV7_LAST) ? 3'h0 : div7Reg + 3'h1;
      end
    end
  end

  // divide by 4 gives a quadrature pair; divide by 7 has no 90 degree tap
  wire shiftZero = divMode ? (div7Reg < `SHIFT_DIV7_HIGH) : johnsonReg[0];
  wire shiftQuad = johnsonReg[1];

  // ----------------------------------------------------------------
  // feedback path and fine delay
  // ----------------------------------------------------------------
  // runtime bus only counts in dynamic mode
  wire [3:0] fbTap = fbDynamic ? runtimeDelayBus[3:0] : dlyReg[`DLY_FB_LSB +: 4];
  wire [3:0] relTap = relDynamic ? runtimeDelayBus[7:4] : dlyReg[`DLY_REL_LSB +: 4];
  reg fbRaw;
  wire fbDelayed;
  wire padDelayed;

  always @* begin
    case (fbPath)
      `PATH_DELAY: fbRaw = synthReg;
      `PATH_PHASE: fbRaw = shiftZero;
      `PATH_OUTSIDE: fbRaw = outsideState;
      default: fbRaw = synthReg;
    endcase
  end

  fine_delay_line uFbDelay (
    .clk(clk),
    .rstn(rstn),
    .dataIn(fbRaw),
    .tapSel(fbTap),
    .dataOut(fbDelayed)
  );

  fine_delay_line uRelDelay (
    .clk(clk),
    .rstn(rstn),
    .dataIn(padState),
    .tapSel(relTap),
    .dataOut(padDelayed)
  );

  // direct path skips the delay stage; all others pass it
  wire fbSignal = (fbPath == `PATH_DIRECT) ? synthReg : fbDelayed;

  // ----------------------------------------------------------------
  // lock detect: feedback edge between every pair of pad edges
  // ----------------------------------------------------------------
  reg padPrevReg;
  reg fbPrevReg;
  reg fbSeenReg;
  reg [4:0] lockCntReg;
  reg lockReg;

  wire padRise = padState && !padPrevReg;
  wire fbRise = fbSignal && !fbPrevReg;

  always @(posedge clk or negedge loopResetN) begin
    if (!loopResetN) begin
      padPrevReg <= 1'b0;
      fbPrevReg <= 1'b0;
      fbSeenReg <= 1'b0;
      lockCntReg <= 5'h00;
      lockReg <= 1'b0;
    end else if (loopHold) begin
      padPrevReg <= 1'b0;
      fbPrevReg <= 1'b0;
      fbSeenReg <= 1'b0;
      lockCntReg <= 5'h00;
      lockReg <= 1'b0;
    end else begin
      padPrevReg <= padState;
      fbPrevReg <= fbSignal;
      // a feedback edge on the pad edge counts for the next window
      fbSeenReg <= fbRise || (fbSeenReg && !padRise);
      if (padRise) begin
        if (!fbSeenReg) begin
          lockCntReg <= 5'h00;
          lockReg <= 1'b0;
        end else if (lockCntReg >= `LOCK_EDGES - 5'h01) begin
          lockReg <= 1'b1;
        end else begin
          lockCntReg <= lockCntReg + 5'h01;
        end
      end
    end
  end

  assign lockOut = lockReg;

  // ----------------------------------------------------------------
  // output selection and low-power freeze
  // ----------------------------------------------------------------
  wire phasePath = (fbPath == `PATH_PHASE);
  wire selValid = (outSel == `SEL_SYNTH) || (outSel == `SEL_HALF) ||
                  (phasePath && (outSel == `SEL_ZERO)) ||
                  (phasePath && (outSel == `SEL_QUAD) && !divMode);
  reg selClk;

  always @* begin
    case (outSel)
      `SEL_ZERO: selClk = shiftZero;
      `SEL_QUAD: selClk = shiftQuad;
      `SEL_HALF: selClk = halfRateReg;
      default: selClk = synthReg;
    endcase
    // an illegal shifter choice falls back to the plain synthesized clock
    if (!selValid) begin
      selClk = synthReg;
    end
  end

  wire lowPowerEff = lowPowerState && pdEnable;
  wire freezeA = lowPowerEff && pdEnableA;
  wire freezeB = lowPowerEff && pdEnableB;
  reg portAReg;
  reg portBReg;

  always @(posedge clk) begin
    if (!rstn) begin
      portAReg <= 1'b0;
      portBReg <= 1'b0;
    end else begin
      if (!freezeA) begin
        portAReg <= padDelayed;
      end
      if (!freezeB) begin
        portBReg <= bypassState ? padState : selClk;
      end
    end
  end

  // one flop feeds both copies so they cannot drift apart
  assign portAGlobalOut = portAReg;
  assign portAFabricOut = portAReg;
  assign portBGlobalOut = portBReg;
  assign portBFabricOut = portBReg;

  // ----------------------------------------------------------------
  // register read, data in the cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      regRdData <= 32'h00000000;
    end else if (regRd) begin
      case (regAddr)
        `CFG_OFFSET: regRdData <= {22'h000000, cfgReg};
        `DLY_OFFSET: regRdData <= {24'h000000, dlyReg};
        `DIV_OFFSET: regRdData <= {16'h0000, divReg};
        `STAT_OFFSET: regRdData <= {26'h0000000, bypassState, freezeB, freezeA,
                                    !selValid, rejectReg, lockReg};
        default: regRdData <= 32'h00000000;
      endcase
    end else begin
      regRdData <= 32'h00000000;
    end
  end
endmodule

// >>> logic/pad_pll_defines.vh
// constants and register map of the pad-sourced clock synthesizer control
//
// How it works
// - feedback from oscillator, fine delay, phase shifter plus delay, or outside input
// - outside feedback input is taken and also passes the fine delay stage
// - feedback fine delay is the fixed setting or runtime bus bits 3..0
// - fixed feedback delay compensates by (n+1) steps of 150 ps; the code makes each step one 25000 ps clock cycle
// - dynamic relative delay comes from runtime bus bits 7..4
// - fixed relative delay puts port A (n+1) steps of 150 ps behind B; the code makes each step one 25000 ps clock cycle
// - phase shifter divides by 4 in mode 0, by 7 in mode 1
// - shifter selections need phase path; quadrature also needs divide mode 0
// - synthesized clock selection drives the output unshifted
// - half-rate selection divides the synthesized clock by two
// - dividers accept 0..15, 0..63, 1..6 and filter range 0..7
// - low-power input ignored unless the power-down enable is set
// - a port freezes only while low power is high and its enable set
// - port A carries the pad clock, port B the synthesized clock
// - lock high means port B is locked to the pad clock
// - the active-low loop reset resets the loop asynchronously
// - bypass connects the reference clock straight to the generated outputs
// - global and fabric versions of port B carry the same clock
// - runtime delay bus honoured only in dynamic delay mode
`ifndef PAD_PLL_DEFINES_VH
`define PAD_PLL_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CFG_OFFSET 8'h00
`define DLY_OFFSET 8'h04
`define DIV_OFFSET 8'h08
`define STAT_OFFSET 8'h0C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFG_PATH_LSB 0
`define CFG_FBMODE_BIT 2
`define CFG_RELMODE_BIT 3
`define CFG_DIVMODE_BIT 4
`define CFG_OUTSEL_LSB 5
`define CFG_PDEN_BIT 7
`define CFG_PDEN_A_BIT 8
`define CFG_PDEN_B_BIT 9
`define DLY_FB_LSB 0
`define DLY_REL_LSB 4
`define DIV_REF_LSB 0
`define DIV_FB_LSB 4
`define DIV_OUT_LSB 10
`define DIV_FILT_LSB 13
`define STAT_LOCK_BIT 0
`define STAT_REJECT_BIT 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CFG_RESET 10'h040
`define DLY_RESET 8'h00
`define DIV_RESET 16'h0400

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define PATH_DIRECT 2'h0
`define PATH_DELAY 2'h1
`define PATH_PHASE 2'h2
`define PATH_OUTSIDE 2'h3
`define SEL_ZERO 2'h0
`define SEL_QUAD 2'h1
`define SEL_SYNTH 2'h2
`define SEL_HALF 2'h3
`define OUT_DIV_MIN 3'h1
`define OUT_DIV_MAX 3'h6
`define SHIFT_DIV7_LAST 3'h6
`define SHIFT_DIV7_HIGH 3'h4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_PS 25000
`define FINE_STEP_PS 150
`define FINE_STEP_CYC (((`FINE_STEP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS) < 1 ? 1 : \
  ((`FINE_STEP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS))
`define LOCK_EDGES 5'h10

`endif

// >>> logic/fine_delay_line.v
// sixteen-step fine delay stage, tap n gives n+1 steps
`timescale 1ns/1ps
`include "pad_pll_defines.vh"

module fine_delay_line (
  clk,
  rstn,
  dataIn,
  tapSel,
  dataOut
);
  input wire clk;
  input wire rstn;
  input wire dataIn;
  input wire [3:0] tapSel;
  output reg dataOut;

  localparam integer STEP_CYC = `FINE_STEP_CYC;
  // the output flop gives the last cycle, so the chain is one flop short
  localparam integer TAPS = 16 * STEP_CYC - 1;

  reg [TAPS-1:0] tapChain;
  wire [TAPS:0] delayLine;
  genvar i;

  assign delayLine = {tapChain, dataIn};

  // ----------------------------------------------------------------
  // tap chain, one flop per clock of a step
  // ----------------------------------------------------------------
  generate
    for (i = 0; i < TAPS; i = i + 1) begin : gTap
      always @(posedge clk) begin
        if (!rstn) begin
          tapChain[i] <= 1'b0;
        end else if (i == 0) begin
          tapChain[i] <= dataIn;
        end else begin
          tapChain[i] <= tapChain[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  // n selects n+1 steps; output flop is part of the last step
  always @(posedge clk) begin
    if (!rstn) begin
      dataOut <= 1'b0;
    end else begin
      dataOut <= delayLine[(tapSel + 5'h01) * STEP_CYC - 5'h01];
    end
  end
endmodule

// >>> dv/pad_pll_checker.sv
// port assertions for the pad-sourced synthesizer control
`timescale 1ns/1ps
module pad_pll_checker (
  input wire clk,
  input wire rstn,
  input wire loopResetN,
  input wire padClockIn,
  input wire bypassIn,
  input wire regRd,
  input wire [31:0] regRdData,
  input wire testSerialOut,
  input wire portAGlobalOut,
  input wire portAFabricOut,
  input wire portBGlobalOut,
  input wire portBFabricOut,
  input wire lockOut
);
  // ----------------------------------------------------------------
  // cycles since loop reset release
  // ----------------------------------------------------------------
  // saturates so a long locked run cannot wrap into a false early value
  reg [7:0] relCnt_reg;
  always @(posedge clk) begin
    if (!rstn || !loopResetN) relCnt_reg <= 8'h00;
    else if (relCnt_reg != 8'hFF) relCnt_reg <= relCnt_reg + 8'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  port_a_pair_a: assert property (portAGlobalOut == portAFabricOut)
    else $error("port A global and fabric differ");
  port_b_pair_a: assert property (portBGlobalOut == portBFabricOut)
    else $error("port B global and fabric differ");
  lock_reset_a: assert property (!loopResetN |-> !lockOut)
    else $error("lock high during loop reset");
  lock_hold_a: assert property ($rose(loopResetN) |-> !lockOut [*8])
    else $error("lock high right after loop reset release");
  lock_rise_a: assert property ($rose(lockOut) |-> loopResetN && relCnt_reg >= 8'h14)
    else $error("lock rose too early");
  read_idle_a: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data outside read cycle");
  test_out_a: assert property (testSerialOut == 1'b0)
    else $error("test serial output not idle");
  bypass_follow_a: assert property ($rose(portBGlobalOut) && bypassIn && $past(bypassIn, 6)
    |-> $past(padClockIn, 2) || $past(padClockIn, 3) || $past(padClockIn, 4))
    else $error("port B rose without pad clock in bypass");
endmodule

bind pad_pll_control pad_pll_checker u_chk (
  .clk(clk),
  .rstn(rstn),
  .loopResetN(loopResetN),
  .padClockIn(padClockIn),
  .bypassIn(bypassIn),
  .regRd(regRd),
  .regRdData(regRdData),
  .testSerialOut(testSerialOut),
  .portAGlobalOut(portAGlobalOut),
  .portAFabricOut(portAFabricOut),
  .portBGlobalOut(portBGlobalOut),
  .portBFabricOut(portBFabricOut),
  .lockOut(lockOut)
);

// >>> dv/fabric_model.sv
// fabric-side partner returning port B as outside feedback
`timescale 1ns/1ps
module fabric_model #(
  parameter EXT_DIVIDE = 1
) (
  input wire clk,
  input wire rstn,
  input wire portAIn,
  input wire portBIn,
  output reg feedbackOut
);
  reg lastB_reg;
  reg [7:0] cnt_reg;
  // port A is pad pass-through, so it never enters the feedback path
  always @(posedge clk) begin
    if (!rstn) begin
      feedbackOut <= 1'b0;
      lastB_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else begin
      lastB_reg <= portBIn;
      if (EXT_DIVIDE == 1) begin
        feedbackOut <= portBIn;
      end else if (portBIn && !lastB_reg) begin
        if (cnt_reg == EXT_DIVIDE - 1) begin
          cnt_reg <= 8'h00;
          feedbackOut <= ~feedbackOut;
        end else begin
          cnt_reg <= cnt_reg + 8'h01;
        end
      end
    end
  end
endmodule

// >>> dv/tb.sv
// self-checking bench for the pad-sourced synthesizer control
`timescale 1ns/1ps
module tb;
  reg clk, rstn, loopResetN, padClockIn, bypassIn, lowPowerIn, testSerialIn, regWr, regRd;
  reg [7:0] runtimeDelayBus, regAddr, dlyVal;
  reg [31:0] regWrData, mE, mM, divv;
  reg [31:0] seed = 32'd80;
  reg [31:0] expQ[$];
  reg [31:0] mskQ[$];
  reg prevA = 0, prevB = 0, rdLast = 0;
  reg [15:0] histB = 16'h0;
  wire [31:0] regRdData;
  wire testSerialOut, portAGlobalOut, portAFabricOut, portBGlobalOut, portBFabricOut;
  wire lockOut, feedback;
  integer error_cnt = 0, total_checks = 0, cycles = 0, riseA = 0, riseB = 0, padCnt = 0;
  integer d, s;

  pad_pll_control u_dut (.clk(clk), .rstn(rstn), .loopResetN(loopResetN),
    .padClockIn(padClockIn), .outsideFeedbackInput(feedback), .bypassIn(bypassIn),
    .lowPowerIn(lowPowerIn), .runtimeDelayBus(runtimeDelayBus), .testSerialIn(testSerialIn),
    .testSerialOut(testSerialOut), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .portAGlobalOut(portAGlobalOut),
    .portAFabricOut(portAFabricOut), .portBGlobalOut(portBGlobalOut),
    .portBFabricOut(portBFabricOut), .lockOut(lockOut));
  fabric_model u_fab (.clk(clk), .rstn(rstn), .portAIn(portAGlobalOut),
    .portBIn(portBGlobalOut), .feedbackOut(feedback));

  // ----------------------------------------------------------------
  // clock, pad clock, edge counters, timeout
  // ----------------------------------------------------------------
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
    if (portAGlobalOut && !prevA) riseA = riseA + 1;
    if (portBGlobalOut && !prevB) riseB = riseB + 1;
    prevA <= portAGlobalOut;
    prevB <= portBGlobalOut;
    rdLast <= regRd;
    histB <= {histB[14:0], portBGlobalOut};
    // pad period of 8 cycles keeps the feedback used in each lock run faster than the pad
    if (padCnt == 3) padClockIn <= ~padClockIn;
    padCnt = (padCnt + 1) % 4;
  end
  always @(negedge clk) begin
    if (rdLast) begin
      mE = expQ.pop_front();
      mM = mskQ.pop_front();
      check("regRdData", mE & mM, regRdData & mM);
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task near(input string nm, input integer e, input integer g);
    begin
      total_checks = total_checks + 1;
      if ((e == 0 && g != 0) || g < e - 1 || g > e + 1) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %s expected %0d seen %0d", nm, e, g);
      end
    end
  endtask
  // in bypass port B is the pad one flop late; port A lags B by n+1 cycles
  task lag_chk(input [3:0] n);
    integer k;
    begin
      for (k = 0; k < 16; k = k + 1) begin
        @(posedge clk);
        check("port A lag", {31'h0, histB[n]}, {31'h0, portAGlobalOut});
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [31:0] m);
    begin
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      expQ.push_back(e);
      mskQ.push_back(m);
      @(posedge clk);
      regRd <= 1'b0;
    end
  endtask
  task wait_lock;
    integer n;
    begin
      n = 0;
      while (lockOut !== 1'b1 && n < 1500) begin
        @(posedge clk);
        n = n + 1;
      end
      check("lockOut", 32'h1, {31'h0, lockOut});
    end
  endtask
  task loop_reset;
    begin
      loopResetN <= 1'b0;
      repeat (3) @(posedge clk);
      check("lockOut", 32'h0, {31'h0, lockOut});
      loopResetN <= 1'b1;
      repeat (10) @(posedge clk);
      check("lockOut", 32'h0, {31'h0, lockOut});
      wait_lock;
    end
  endtask
  // counts rising edges of both ports over a fixed window after a settle time
  task meas(input [9:0] cfg, input integer expB, input integer expA);
    integer bA, bB;
    begin
      wr(8'h00, {22'h0, cfg});
      seed = xs(seed);
      runtimeDelayBus <= seed[7:0];
      repeat (24) @(posedge clk);
      bA = riseA;
      bB = riseB;
      repeat (400) @(posedge clk);
      near("port B rises", expB, riseB - bB);
      near("port A rises", expA, riseA - bA);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 0;
    loopResetN = 1;
    padClockIn = 0;
    bypassIn = 0;
    lowPowerIn = 0;
    testSerialIn = 0;
    regWr = 0;
    regRd = 0;
    regAddr = 0;
    regWrData = 0;
    runtimeDelayBus = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h00, 32'h040, 32'hFFFFFFFF);
    rd(8'h04, 32'h0, 32'hFFFFFFFF);
    rd(8'h08, 32'h0400, 32'hFFFFFFFF);
    rd(8'h0C, 32'h0, 32'h3F);
    wr(8'h10, 32'hFFFF);
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    seed = xs(seed);
    wr(8'h04, {24'h0, seed[7:0]});
    rd(8'h04, {24'h0, seed[7:0]}, 32'hFF);
    dlyVal = seed[7:0];
    divv = 32'h0400;
    for (d = 0; d < 8; d = d + 1) begin
      wr(8'h08, {16'h0, 3'h7, d[2:0], 6'h3F, 4'hF});
      if (d >= 1 && d <= 6) divv = {16'h0, 3'h7, d[2:0], 6'h3F, 4'hF};
      rd(8'h08, divv, 32'hFFFF);
    end
    rd(8'h0C, 32'h2, 32'h2);
    wr(8'h0C, 32'h2);
    rd(8'h0C, 32'h0, 32'h2);
    wr(8'h08, 32'h0400);
    wait_lock;
    rd(8'h0C, 32'h1, 32'h1);
    loop_reset;
    for (s = 0; s < 2; s = s + 1)
      for (d = 1; d < 7; d = d + 1) begin
        wr(8'h08, {16'h0, 3'h0, d[2:0], 10'h0});
        meas(s ? 10'h060 : 10'h040, (s ? 100 : 200) / d, 50);
      end
    wr(8'h08, 32'h0400);
    meas(10'h002, 50, 50);
    meas(10'h022, 50, 50);
    meas(10'h012, 28, 50);
    meas(10'h032, 200, 50);
    rd(8'h0C, 32'h4, 32'h4);
    meas(10'h000, 200, 50);
    meas(10'h04C, 200, 50);
    meas(10'h043, 200, 50);
    // the pin filter drops one-cycle pulses, so slow the feedback to lock
    wr(8'h08, 32'h0800);
    loop_reset;
    wr(8'h08, 32'h0400);
    bypassIn <= 1'b1;
    meas(10'h040, 50, 50);
    lag_chk(dlyVal[7:4]);
    rd(8'h0C, 32'h20, 32'h20);
    meas(10'h048, 50, 50);
    lag_chk(runtimeDelayBus[7:4]);
    bypassIn <= 1'b0;
    lowPowerIn <= 1'b1;
    meas(10'h240, 200, 50);
    meas(10'h1C0, 200, 0);
    meas(10'h3C0, 0, 0);
    rd(8'h0C, 32'h18, 32'h18);
    lowPowerIn <= 1'b0;
    repeat (4) @(posedge clk);
    close_out;
  end
endmodule
